/* dv/frame_timestamp_and_buffer_flag_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module frame_timestamp_and_buffer_flag_tb_top
    import ftbf_pkg::*;
;
    logic mclk = 0, rst = 1, rxHeaderValid = 0, txStart = 0, aretMode = 0, frameEnd = 0;
    logic rxError = 0, irqPending = 0, fbByteReady = 1, antSwitchEnable = 0, antSwitchLevel = 0;
    logic cmdGo = 0, busy, rdValid, timeout, stampLevel, irqLevel, fbTaken;
    logic [7:0] fbData = 8'h5a, cmdData = 8'h00, frameLen = 8'h00, rdData;
    logic [5:0] cmdAddr = 6'h00;
    ftbf_kind_type cmdKind = FTBF_REG_RD;
    int mismatches = 0, checks = 0, toCnt = 0;
    logic [7:0] rdQ[$];

    ftbf_if busIf();
    ftbf_device ftbf_device_inst (.mclk, .rst, .io(busIf.dev), .rxHeaderValid, .txStart,
        .aretMode, .frameEnd, .rxError, .irqPending, .fbByteReady, .fbData, .fbTaken,
        .antSwitchEnable, .antSwitchLevel);
    ftbf_host ftbf_host_inst (.mclk, .rst, .io(busIf.host), .cmdGo, .cmdKind, .cmdAddr,
        .cmdData, .frameLen, .busy, .rdData, .rdValid, .timeout, .stampLevel, .irqLevel);
    ftbf_props ftbf_props_inst (.mclk, .rst, .selN(busIf.selN), .sclk(busIf.sclk),
        .mosi(busIf.mosi), .miso(busIf.miso), .irqPin(busIf.irqPin),
        .timestampPin(busIf.timestampPin));

    // Clock of 20 ns.
    always #10 mclk = ~mclk;

    // Collects read bytes and counts aborted reads, away from the launching edge.
    always @(negedge mclk) begin
        if (rdValid === 1'b1) rdQ.push_back(rdData);
        if (timeout === 1'b1) toCnt++;
    end

    // Offers the next buffer byte once one is taken.
    always @(negedge mclk) begin
        if (fbTaken === 1'b1) fbData <= fbData + 8'h11;
    end

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic xfer(input ftbf_kind_type k, input logic [5:0] a, input logic [7:0] d, n);
        int w = 0;
        @(negedge mclk);
        cmdKind = k;
        cmdAddr = a;
        cmdData = d;
        frameLen = n;
        cmdGo = 1'b1;
        @(negedge mclk);
        cmdGo = 1'b0;
        while (busy !== 1'b0 && w < 20000) begin
            @(negedge mclk);
            w++;
        end
        if (w >= 20000) mismatches++;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        xfer(FTBF_REG_WR, a, d, 8'h00);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        rdQ.delete();
        xfer(FTBF_REG_RD, a, 8'h00, 8'h00);
        `CHK(rdQ.size() == 1 ? rdQ[0] : 8'hxx, exp)
    endtask

    // Sets the enables, raises one radio event and ends the frame.
    task automatic stamp(input logic [7:0] c, m, e, input logic ar, rx, tx, exp);
        wr(ADDR_TRX_CTRL1, c);
        wr(ADDR_IRQ_MASK, m);
        wr(ADDR_EXT_CTRL1, e);
        aretMode = ar;
        rxHeaderValid = rx;
        txStart = tx;
        @(negedge mclk);
        rxHeaderValid = 1'b0;
        txStart = 1'b0;
        repeat (20) @(negedge mclk);
        `CHK(busIf.timestampPin, exp)
        `CHK(stampLevel, exp)
        frameEnd = 1'b1;
        @(negedge mclk);
        frameEnd = 1'b0;
        @(negedge mclk);
        `CHK(busIf.timestampPin, 1'b0)
    endtask

    // Runs a transfer, looks at the interrupt pin midway, then marks data ready.
    task automatic probed(input ftbf_kind_type k, input logic [7:0] len, input logic p);
        rdQ.delete();
        fork
            xfer(k, ADDR_TRX_CTRL1, 8'h00, len);
            begin
                repeat (100) @(negedge mclk);
                `CHK(busIf.irqPin, p)
                repeat (100) @(negedge mclk);
                fbByteReady = 1'b1;
            end
        join
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        rd(ADDR_TRX_CTRL1, 8'h22);
        rd(ADDR_IRQ_MASK, 8'hff);
        rd(ADDR_EXT_CTRL1, 8'h00);
        rd(6'h3f, 8'h00);
        wr(ADDR_EXT_CTRL1, 8'hff);
        rd(ADDR_EXT_CTRL1, 8'hf7);
        $display("test registers finished");
        stamp(8'h22, 8'hff, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0);
        stamp(8'h62, 8'hff, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
        stamp(8'h62, 8'hff, 8'h80, 1'b0, 1'b0, 1'b1, 1'b0);
        stamp(8'h62, 8'hff, 8'h00, 1'b1, 1'b0, 1'b1, 1'b0);
        stamp(8'h62, 8'hff, 8'h80, 1'b1, 1'b0, 1'b1, 1'b1);
        stamp(8'h22, 8'hff, 8'h80, 1'b1, 1'b0, 1'b1, 1'b0);
        stamp(8'h22, 8'hfb, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
        wr(ADDR_IRQ_MASK, 8'hff);
        antSwitchEnable = 1'b1;
        antSwitchLevel = 1'b1;
        wr(ADDR_TRX_CTRL1, 8'h62);
        `CHK(busIf.timestampPin, 1'b0)
        wr(ADDR_TRX_CTRL1, 8'h22);
        `CHK(busIf.timestampPin, 1'b1)
        antSwitchEnable = 1'b0;
        $display("test stamp finished");
        wr(ADDR_TRX_CTRL1, 8'h32);
        fbByteReady = 1'b0;
        irqPending = 1'b1;
        probed(FTBF_FB_RD, 8'h02, 1'b1);
        `CHK(busIf.irqPin, 1'b1)
        `CHK(irqLevel, 1'b1)
        `CHK(rdQ.size(), 2)
        `CHK(rdQ[0], 8'h5a)
        `CHK(rdQ[1], 8'h6b)
        probed(FTBF_REG_RD, 8'h00, 1'b1);
        `CHK(rdQ[0], 8'h32)
        irqPending = 1'b0;
        wr(ADDR_TRX_CTRL1, 8'h22);
        fbData = 8'h7c;
        probed(FTBF_FB_RD, 8'h01, 1'b0);
        `CHK(rdQ[0], 8'h7c)
        $display("test flag finished");
        wr(ADDR_TRX_CTRL1, 8'h32);
        fbByteReady = 1'b0;
        fork
            probed(FTBF_FB_RD, 8'h01, 1'b1);
            begin
                repeat (150) @(negedge mclk);
                rxError = 1'b1;
                @(negedge mclk);
                rxError = 1'b0;
            end
        join
        `CHK(toCnt, 1)
        `CHK(rdQ.size(), 0)
        $display("test receive error finished");
        final_report();
    end

    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire

/* dv/ftbf_props.sv */
`timescale 1ns/1ns
`default_nettype none
module ftbf_props
    import ftbf_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst,
    // Interface signals.
    input wire logic selN,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso,
    input wire logic irqPin,
    input wire logic timestampPin
);
    logic        sclkQ;
    logic        flagEn;
    logic        flagWin;
    logic [7:0]  shReg;
    logic [7:0]  cmdReg;
    logic [11:0] bitCnt;
    logic [11:0] winCnt;
    logic [12:0] hiCnt;
    logic        sclkRise;
    logic [7:0]  nextByte;

    // Serial clock rise and the byte being shifted in.
    assign sclkRise = sclk && !sclkQ;
    assign nextByte = {shReg[6:0], mosi};

    // Follows the flag enable, the command byte and the flag window.
    always_ff @(posedge mclk) begin
        sclkQ <= sclk;
        if (rst) begin
            flagEn <= TRX_CTRL1_RST[FLAG_EN_BIT];
        end else if (sclkRise && !selN && bitCnt == 12'h00f && cmdReg == 8'hc4) begin
            flagEn <= nextByte[FLAG_EN_BIT];
        end
        if (rst || selN) begin
            bitCnt <= 12'h000;
            flagWin <= 1'b0;
            winCnt <= 12'h000;
            hiCnt <= 13'h0000;
        end else begin
            winCnt <= flagWin ? winCnt + 12'h001 : 12'h000;
            hiCnt <= irqPin ? hiCnt + 13'h0001 : 13'h0000;
            if (sclkRise) begin
                bitCnt <= bitCnt + 12'h001;
                shReg <= nextByte;
                if (bitCnt == 12'h007) begin
                    cmdReg <= nextByte;
                    flagWin <= flagEn && ((nextByte & KIND_MASK_FB) == KIND_FB_RD);
                end
            end
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_stamp_reset: assert property ($fell(rst) |-> !timestampPin)
        else $error("stamp pin high after reset");
    a_irq_reset: assert property ($fell(rst) |-> !irqPin)
        else $error("interrupt pin high after reset");
    a_flag_settle: assert property (flagWin && winCnt >= 12'h00a && winCnt < 12'h024
        |-> irqPin)
        else $error("flag low during settle time");
    a_early_ready: assert property (flagWin && bitCnt == 12'h008 && $fell(irqPin)
        |-> winCnt >= T12_CYC)
        else $error("flag valid too early");
    a_byte_busy: assert property (flagWin && sclkRise && bitCnt[2:0] == 3'h7
        && bitCnt > 12'h008 |-> ##[2:8] irqPin)
        else $error("flag not raised after byte");
    a_host_waits: assert property (flagWin && sclkRise && bitCnt[2:0] == 3'h0
        |-> !$past(irqPin, 2))
        else $error("byte clocked while flag high");
    a_sclk_idle: assert property (selN |-> !sclk)
        else $error("serial clock runs while deselected");
    a_host_abort: assert property (hiCnt < {1'b0, TIMEOUT_CYC} + 13'h0c8)
        else $error("host kept select past timeout");
endmodule
`default_nettype wire

/* logic/ftbf_device.sv */
// Behaviour
// RULE1 - Stamp pin rises on header or transmit start
// RULE2 - Stamp pin stays high until frame ends
// RULE3 - Transmit stamps only in auto-retry mode
// RULE4 - Unused stamp pin held low
// RULE5 - Control bit 6 enables stamp output
// RULE6 - Cleared receive-start mask also enables pin
// RULE7 - Extended bit 7 enables retry transmit stamps
// RULE8 - Host sets both enables for transmit stamps
// RULE9 - Control bit turns interrupt pin into flag
// RULE10 - Flag from read command until select high
// RULE11 - Flag low when data ready, else high
// RULE12 - Host clocks bytes only while flag low
// RULE13 - Flag valid 750 ns after command byte
// RULE14 - Pending interrupts shown right after select high
// RULE15 - Other accesses show only interrupts
// RULE16 - Receive error locks flag at empty
// RULE17 - Host aborts after 64 us flag high
// RULE18 - Stamping has priority over antenna control
// RULE19 - Select and clock synchronised before use
`timescale 1ns/1ns
`default_nettype none
module ftbf_device
    import ftbf_pkg::*;
(
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst,
    // Serial port and status pins.
    ftbf_if.dev             io,
    // Radio events.
    input  wire logic       rxHeaderValid,
    input  wire logic       txStart,
    input  wire logic       aretMode,
    input  wire logic       frameEnd,
    input  wire logic       rxError,
    // Interrupt source.
    input  wire logic       irqPending,
    // Frame buffer read side.
    input  wire logic       fbByteReady,
    input  wire logic [7:0] fbData,
    output logic            fbTaken,
    // Antenna switch leg sharing the stamp pin.
    input  wire logic       antSwitchEnable,
    input  wire logic       antSwitchLevel
);

    // Serial transfer phases.
    typedef enum logic [4:0] {
        PH_CMD  = 5'h01,
        PH_RD   = 5'h02,
        PH_WR   = 5'h04,
        PH_FB   = 5'h08,
        PH_SKIP = 5'h10
    } ftbf_phase_type;

    typedef struct packed {
        logic [1:0]     selSync;
        logic [1:0]     sclkSync;
        logic [1:0]     mosiSync;
        logic           sclkPrev;
        logic [2:0]     bitCnt;
        logic [7:0]     shiftIn;
        logic [7:0]     shiftOut;
        logic [7:0]     cmd;
        ftbf_phase_type phase;
        logic [7:0]     trxCtrl1;
        logic [7:0]     irqMask;
        logic [7:0]     extCtrl1;
        logic           flagMode;
        logic           needLoad;
        logic [11:0]    waitCnt;
        logic           lockEmpty;
        logic           stamp;
        logic           miso;
        logic           irqPin;
        logic           tsPin;
        logic           fbTaken;
    } ftbf_dev_state_type;

    ftbf_dev_state_type q;
    ftbf_dev_state_type next_q;

    // Register read decode.
    function automatic logic [7:0] regRead(input ftbf_dev_state_type s,
                                           input logic [5:0] a);
        case (a)
            ADDR_TRX_CTRL1: return s.trxCtrl1;
            ADDR_IRQ_MASK:  return s.irqMask;
            ADDR_EXT_CTRL1: return s.extCtrl1;
            default:        return 8'h00;
        endcase
    endfunction

    logic       selN;
    logic       sclkRise;
    logic       sclkFall;
    logic [7:0] byteIn;
    logic       rxStampEn;
    logic       txStampEn;

    // Stamp enables decoded from the control registers, with the transmit enable also gated by aretMode.
    always_comb begin
        rxStampEn = q.trxCtrl1[TS_OUT_EN_BIT] | ~q.irqMask[RX_START_MSK_BIT]; // [RULE5] [RULE6]
        txStampEn = q.trxCtrl1[TS_OUT_EN_BIT] & q.extCtrl1[RETRY_TS_EN_BIT]
                    & aretMode; // [RULE3] [RULE7] [RULE8]
    end

    // Synchronised pins and edge detection, using only second stages.
    always_comb begin
        selN     = q.selSync[1]; // [RULE19]
        sclkRise = q.sclkSync[1] & ~q.sclkPrev; // [RULE19]
        sclkFall = ~q.sclkSync[1] & q.sclkPrev;
        byteIn   = {q.shiftIn[6:0], q.mosiSync[1]};
    end

    // Next-state logic for the whole block.
    always_comb begin
        next_q          = q;
        next_q.fbTaken  = 1'b0;
        next_q.selSync  = {q.selSync[0], io.selN};
        next_q.sclkSync = {q.sclkSync[0], io.sclk};
        next_q.mosiSync = {q.mosiSync[0], io.mosi};
        next_q.sclkPrev = q.sclkSync[1];

        if (selN) begin
            // Deselect ends every transfer and closes the flag window.
            next_q.bitCnt    = 3'h0;
            next_q.phase     = PH_CMD;
            next_q.flagMode  = 1'b0; // [RULE10] [RULE14]
            next_q.needLoad  = 1'b0;
            next_q.waitCnt   = 12'h000;
            next_q.lockEmpty = 1'b0;
            next_q.shiftOut  = 8'h00;
            next_q.miso      = 1'b0;
        end else begin
            if (sclkRise) begin
                next_q.shiftIn = byteIn;
                next_q.bitCnt  = q.bitCnt + 3'h1;
                if (q.bitCnt == BIT_LAST) begin
                    case (q.phase)
                        PH_CMD: begin
                            next_q.cmd = byteIn;
                            if (isRegRead(byteIn)) begin
                                next_q.phase    = PH_RD;
                                next_q.shiftOut = regRead(q, byteIn[5:0]);
                                next_q.miso     = next_q.shiftOut[7];
                            end else if (isRegWrite(byteIn)) begin
                                next_q.phase = PH_WR;
                            end else if (isFrameRead(byteIn)) begin
                                next_q.phase    = PH_FB;
                                next_q.needLoad = 1'b1;
                                next_q.flagMode = q.trxCtrl1[FLAG_EN_BIT]; // [RULE9] [RULE10]
                                next_q.waitCnt  = q.trxCtrl1[FLAG_EN_BIT] ?
                                                  T12_CYC : 12'h000; // [RULE13]
                            end else begin
                                next_q.phase = PH_SKIP;
                            end
                        end
                        PH_WR: begin
                            // Write the addressed register, keeping read-only bits.
                            case (q.cmd[5:0])
                                ADDR_TRX_CTRL1: next_q.trxCtrl1 = byteIn;
                                ADDR_IRQ_MASK:  next_q.irqMask  = byteIn;
                                ADDR_EXT_CTRL1: next_q.extCtrl1 =
                                    (byteIn & EXT_WRITE_MASK) |
                                    (q.extCtrl1 & ~EXT_WRITE_MASK);
                                default:        next_q.extCtrl1 = q.extCtrl1;
                            endcase
                            next_q.phase = PH_SKIP;
                        end
                        PH_FB: begin
                            next_q.needLoad = 1'b1; // [RULE11]
                        end
                        default: begin
                            next_q.phase = PH_SKIP;
                        end
                    endcase
                end
            end
            // Shift the answer out on falling edges, but not at byte start.
            if (sclkFall && q.bitCnt != 3'h0) begin
                next_q.miso     = q.shiftOut[6];
                next_q.shiftOut = {q.shiftOut[6:0], 1'b0};
            end
            if (q.waitCnt != 12'h000) begin
                next_q.waitCnt = q.waitCnt - 12'h001; // [RULE13]
            end
            if (q.phase == PH_FB && rxError) begin
                next_q.lockEmpty = 1'b1; // [RULE16]
            end
            // Load the next buffer byte once it is available.
            if (q.phase == PH_FB && q.needLoad && q.waitCnt == 12'h000
                && fbByteReady && !q.lockEmpty && !rxError && !sclkRise) begin
                next_q.needLoad = 1'b0;
                next_q.shiftOut = fbData;
                next_q.miso     = fbData[7];
                next_q.fbTaken  = 1'b1;
            end
        end

        // Interrupt pin carries the flag only inside the window.
        next_q.irqPin = next_q.flagMode ?
                        (next_q.needLoad | next_q.lockEmpty) :
                        irqPending; // [RULE10] [RULE11] [RULE14] [RULE15] [RULE16]

        // Frame stamp: set on start events, held until frame end.
        if (frameEnd) begin
            next_q.stamp = 1'b0; // [RULE2]
        end
        if ((rxHeaderValid && rxStampEn) || (txStart && txStampEn)) begin
            next_q.stamp = 1'b1; // [RULE1] [RULE3]
        end
        if (q.trxCtrl1[TS_OUT_EN_BIT] || !q.irqMask[RX_START_MSK_BIT]) begin
            next_q.tsPin = next_q.stamp; // [RULE18]
        end else if (antSwitchEnable) begin
            next_q.tsPin = antSwitchLevel;
        end else begin
            next_q.tsPin = 1'b0; // [RULE4]
        end
    end

    // State register with reset to register defaults.
    always_ff @(posedge mclk) begin
        if (rst) begin
            q          <= '0;
            q.selSync  <= 2'h3;
            q.phase    <= PH_CMD;
            q.trxCtrl1 <= TRX_CTRL1_RST;
            q.irqMask  <= IRQ_MASK_RST;
            q.extCtrl1 <= EXT_CTRL1_RST;
        end else begin
            q <= next_q;
        end
    end

    // Pins come straight from state flip-flops.
    assign io.miso         = q.miso;
    assign io.irqPin       = q.irqPin;
    assign io.timestampPin = q.tsPin;
    assign fbTaken         = q.fbTaken;

endmodule
`default_nettype wire

/* logic/ftbf_host.sv */
`timescale 1ns/1ns
`default_nettype none
module ftbf_host
    import ftbf_pkg::*;
(
    // Clock and reset.
    input  wire logic          mclk,
    input  wire logic          rst,
    // Serial port and status pins.
    ftbf_if.host               io,
    // Command request.
    input  wire logic          cmdGo,
    input  wire ftbf_kind_type cmdKind,
    input  wire logic [5:0]    cmdAddr,
    input  wire logic [7:0]    cmdData,
    input  wire logic [7:0]    frameLen,
    // Results and status.
    output logic               busy,
    output logic [7:0]         rdData,
    output logic               rdValid,
    output logic               timeout,
    output logic               stampLevel,
    output logic               irqLevel
);

    typedef enum logic [4:0] {
        H_IDLE = 5'h01,
        H_SEL  = 5'h02,
        H_BIT  = 5'h04,
        H_WAIT = 5'h08,
        H_END  = 5'h10
    } ftbf_hstate_type;

    typedef struct packed {
        logic [1:0]      irqSync;
        logic [1:0]      tsSync;
        logic [1:0]      misoSync;
        ftbf_hstate_type state;
        ftbf_kind_type   kind;
        logic            firstByte;
        logic [7:0]      wrData;
        logic [7:0]      remaining;
        logic [2:0]      bitCnt;
        logic [2:0]      div;
        logic [7:0]      txShift;
        logic [7:0]      rxShift;
        logic [11:0]     waitCnt;
        logic [11:0]     tmo;
        logic            selN;
        logic            sclk;
        logic            mosi;
        logic            busy;
        logic [7:0]      rdData;
        logic            rdValid;
        logic            timeout;
    } ftbf_host_state_type;

    ftbf_host_state_type q;
    ftbf_host_state_type next_q;
    logic [7:0]          rxByte;

    // Next-state logic.
    always_comb begin
        next_q          = q;
        next_q.rdValid  = 1'b0;
        next_q.timeout  = 1'b0;
        next_q.irqSync  = {q.irqSync[0], io.irqPin};
        next_q.tsSync   = {q.tsSync[0], io.timestampPin};
        next_q.misoSync = {q.misoSync[0], io.miso};
        rxByte          = {q.rxShift[6:0], q.misoSync[1]};
        case (q.state)
            H_IDLE: begin
                if (cmdGo) begin
                    next_q.kind      = cmdKind;
                    next_q.wrData    = cmdData;
                    next_q.remaining = frameLen;
                    next_q.firstByte = 1'b1;
                    next_q.txShift   = (cmdKind == FTBF_FB_RD) ? KIND_FB_RD :
                                       (cmdKind == FTBF_REG_WR) ?
                                       (KIND_REG_WR | {2'h0, cmdAddr}) :
                                       (KIND_REG_RD | {2'h0, cmdAddr});
                    next_q.selN      = 1'b0;
                    next_q.busy      = 1'b1;
                    next_q.waitCnt   = GAP_CYC;
                    next_q.state     = H_SEL;
                end
            end
            H_SEL: begin
                // Setup time from select low to the first clock.
                if (q.waitCnt != 12'h000) begin
                    next_q.waitCnt = q.waitCnt - 12'h001;
                end else begin
                    next_q.div    = 3'h0;
                    next_q.bitCnt = 3'h0;
                    next_q.mosi   = q.txShift[7];
                    next_q.state  = H_BIT;
                end
            end
            H_BIT: begin
                next_q.div = q.div + 3'h1;
                if (q.div == SCLK_HALF) begin
                    next_q.sclk = 1'b1;
                end
                if (q.div == SCLK_LAST) begin
                    // Sample at the end of the high half, then drop the clock.
                    next_q.sclk    = 1'b0;
                    next_q.rxShift = rxByte;
                    next_q.bitCnt  = q.bitCnt + 3'h1;
                    next_q.mosi    = q.txShift[6];
                    next_q.txShift = {q.txShift[6:0], 1'b0};
                    if (q.bitCnt == BIT_LAST) begin
                        next_q.firstByte = 1'b0;
                        if (q.firstByte && q.kind != FTBF_FB_RD) begin
                            next_q.txShift = (q.kind == FTBF_REG_WR) ?
                                             q.wrData : 8'h00;
                            next_q.mosi    = (q.kind == FTBF_REG_WR) ?
                                             q.wrData[7] : 1'b0;
                        end else if (q.firstByte) begin
                            // Flag is not valid until the settle time passes.
                            next_q.waitCnt = T12_CYC + GAP_CYC; // [RULE13]
                            next_q.tmo     = 12'h000;
                            next_q.state   = (q.remaining == 8'h00) ? H_END : H_WAIT;
                        end else begin
                            next_q.rdData  = rxByte;
                            next_q.rdValid = 1'b1;
                            next_q.waitCnt = GAP_CYC;
                            next_q.tmo     = 12'h000;
                            if (q.kind != FTBF_FB_RD || q.remaining == 8'h01) begin
                                next_q.state = H_END;
                            end else begin
                                next_q.remaining = q.remaining - 8'h01;
                                next_q.state     = H_WAIT;
                            end
                        end
                    end
                end
            end
            H_WAIT: begin
                if (q.waitCnt != 12'h000) begin
                    next_q.waitCnt = q.waitCnt - 12'h001;
                end else if (!q.irqSync[1]) begin
                    next_q.div    = 3'h0;
                    next_q.bitCnt = 3'h0;
                    next_q.mosi   = 1'b0;
                    next_q.state  = H_BIT; // [RULE12]
                end else if (q.tmo == TIMEOUT_CYC - 12'h001) begin
                    next_q.timeout = 1'b1; // [RULE17]
                    next_q.waitCnt = GAP_CYC;
                    next_q.state   = H_END;
                end else begin
                    next_q.tmo = q.tmo + 12'h001;
                end
            end
            H_END: begin
                next_q.selN = 1'b1;
                next_q.sclk = 1'b0;
                if (q.waitCnt != 12'h000) begin
                    next_q.waitCnt = q.waitCnt - 12'h001;
                end else begin
                    next_q.busy  = 1'b0;
                    next_q.state = H_IDLE;
                end
            end
            default: begin
                next_q.state = H_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (rst) begin
            q       <= '0;
            q.state <= H_IDLE;
            q.selN  <= 1'b1;
            q.kind  <= FTBF_REG_RD;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from flip-flops.
    assign io.selN    = q.selN;
    assign io.sclk    = q.sclk;
    assign io.mosi    = q.mosi;
    assign busy       = q.busy;
    assign rdData     = q.rdData;
    assign rdValid    = q.rdValid;
    assign timeout    = q.timeout;
    assign stampLevel = q.tsSync[1];
    assign irqLevel   = q.irqSync[1];

endmodule
`default_nettype wire

/* logic/ftbf_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ftbf_if;
    logic selN;
    logic sclk;
    logic mosi;
    logic miso;
    logic irqPin;
    logic timestampPin;

    // Transceiver end.
    modport dev (
        input  selN, sclk, mosi,
        output miso, irqPin, timestampPin
    );
    // Microcontroller end.
    modport host (
        output selN, sclk, mosi,
        input  miso, irqPin, timestampPin
    );
endinterface
`default_nettype wire

/* logic/ftbf_pkg.sv */
`default_nettype none
package ftbf_pkg;
    // Register addresses reached over the serial port.
    localparam logic [5:0] ADDR_TRX_CTRL1 = 6'h04;
    localparam logic [5:0] ADDR_IRQ_MASK  = 6'h0e;
    localparam logic [5:0] ADDR_EXT_CTRL1 = 6'h17;
    // Field positions.
    localparam int TS_OUT_EN_BIT    = 6;
    localparam int FLAG_EN_BIT      = 4;
    localparam int RETRY_TS_EN_BIT  = 7;
    localparam int RX_START_MSK_BIT = 2;
    // Reset values and the writable bits of the extended register.
    localparam logic [7:0] TRX_CTRL1_RST  = 8'h22;
    localparam logic [7:0] EXT_CTRL1_RST  = 8'h00;
    localparam logic [7:0] IRQ_MASK_RST   = 8'hff;
    localparam logic [7:0] EXT_WRITE_MASK = 8'hf7;
    // Command byte encodings.
    localparam logic [7:0] KIND_MASK_REG = 8'hc0;
    localparam logic [7:0] KIND_REG_RD   = 8'h80;
    localparam logic [7:0] KIND_REG_WR   = 8'hc0;
    localparam logic [7:0] KIND_MASK_FB  = 8'he0;
    localparam logic [7:0] KIND_FB_RD    = 8'h20;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    // Timing, in nanoseconds, microseconds and derived clock cycles.
    localparam int CLK_NS      = 20;
    localparam int T12_NS      = 750;
    localparam int TIMEOUT_US  = 64;
    localparam logic [11:0] T12_CYC     = 12'((T12_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] TIMEOUT_CYC = 12'(TIMEOUT_US * 1000 / CLK_NS);
    localparam logic [11:0] GAP_CYC     = 12'h008;
    localparam logic [2:0]  SCLK_HALF   = 3'h3;
    localparam logic [2:0]  SCLK_LAST   = 3'h7;

    // Host transfer kinds.
    typedef enum logic [1:0] {
        FTBF_REG_RD = 2'h0,
        FTBF_REG_WR = 2'h1,
        FTBF_FB_RD  = 2'h2
    } ftbf_kind_type;

    // Command byte decoding used by the device end.
    function automatic logic isRegRead(input logic [7:0] b);
        return (b & KIND_MASK_REG) == KIND_REG_RD;
    endfunction
    function automatic logic isRegWrite(input logic [7:0] b);
        return (b & KIND_MASK_REG) == KIND_REG_WR;
    endfunction
    function automatic logic isFrameRead(input logic [7:0] b);
        return (b & KIND_MASK_FB) == KIND_FB_RD;
    endfunction
endpackage
`default_nettype wire
